// [rtl/sdram_ctl_end.sv]
// Controller end: power-up sequence, then single-word read and write requests.
// Assumes the user holds a request until o_ack; one request at a time.
module sdram_ctl_end
#(
    parameter int PAUSE_CYC = `SD_PAUSE_CYC,
    parameter int TRSC = `SD_TRSC_CYC,
    parameter int TRCD = `SD_TRCD_CYC,
    parameter int TRP = `SD_TRP_CYC,
    parameter int TRC = `SD_TRC_CYC,
    parameter int TRFC = `SD_TRFC_CYC,
    parameter int CAS_LAT = `SD_CAS_LAT,
    parameter logic [`SD_ADDR_W-1:0] MODE_VAL = 11'h020
)
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    sdram_link_if.ctl link,
    input wire logic i_req,
    input wire logic i_we,
    input wire logic i_ba,
    input wire sdram_cmd_pkg::sd_addr_t i_row,
    input wire logic [`SD_COL_W-1:0] i_col,
    input wire sdram_cmd_pkg::sd_data_t i_wdata,
    input wire logic [1:0] i_mask,
    output logic o_ready,
    output logic o_ack,
    output sdram_cmd_pkg::sd_data_t o_rdata
);
    import sdram_cmd_pkg::*;
    typedef enum logic [3:0] {
        S_PAUSE = 4'h0,
        S_PREALL = 4'h1,
        S_REF = 4'h2,
        S_MRS = 4'h3,
        S_IDLE = 4'h4,
        S_ACT = 4'h5,
        S_ACC = 4'h6,
        S_RDW = 4'h7,
        S_PRE = 4'h8,
        S_WAIT = 4'h9
    } st_e;
    localparam int CW = 16;

    st_e st_ff, nxt_st, ret_ff, nxt_ret;
    logic [CW-1:0] cnt_ff, nxt_cnt;
    logic [3:0] ref_ff, nxt_ref;
    sd_cmd_e cmd_ff, nxt_cmd;
    sd_addr_t addr_ff, nxt_addr;
    logic ba_ff, nxt_ba;
    logic [1:0] dqm_ff, nxt_dqm;
    logic oe_n_ff, nxt_oe_n;
    logic ack_ff, rdy_ff;
    sd_data_t rdata_ff;

    // Wait n cycles, where n counts whole cycles
    function automatic logic [CW-1:0] dly(input int n);
        dly = (n > 1) ? CW'(n - 1) : '0;
    endfunction

    wire cnt_done = cnt_ff == '0;
    wire cap_rd = st_ff == S_RDW && cnt_done;

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_comb
    begin
        nxt_st = st_ff;
        nxt_ret = ret_ff;
        nxt_cnt = cnt_done ? cnt_ff : cnt_ff - 1'b1;
        nxt_ref = ref_ff;
        nxt_cmd = CMD_NOP;
        nxt_addr = addr_ff;
        nxt_ba = ba_ff;
        nxt_dqm = 2'h3;
        nxt_oe_n = 1'b1;
        case (st_ff)
            S_PAUSE:
                if (cnt_done)
                begin
                    nxt_cmd = CMD_PRE;
                    nxt_addr = sd_addr_t'(1) << `SD_ALLBANK_BIT;
                    nxt_cnt = dly(TRP);
                    nxt_ret = S_REF;
                    nxt_st = S_WAIT;
                end
            S_REF:
                if (ref_ff == 4'(`SD_INIT_REFRESH))
                    nxt_st = S_MRS;
                else
                begin
                    nxt_cmd = CMD_REF;
                    nxt_ref = ref_ff + 1'b1;
                    nxt_cnt = dly(TRFC);
                    nxt_ret = S_REF;
                    nxt_st = S_WAIT;
                end
            S_MRS:
            begin
                // Banks idle and enable high for many cycles by now
                nxt_cmd = CMD_MRS;
                nxt_addr = MODE_VAL;
                nxt_cnt = dly(TRSC);
                nxt_ret = S_IDLE;
                nxt_st = S_WAIT;
            end
            S_IDLE:
                if (i_req)
                begin
                    nxt_cmd = CMD_ACT;
                    nxt_ba = i_ba;
                    nxt_addr = i_row;
                    nxt_cnt = dly(TRCD);
                    nxt_ret = S_ACC;
                    nxt_st = S_WAIT;
                end
            S_ACC:
            begin
                nxt_cmd = i_we ? CMD_WR : CMD_RD;
                nxt_addr = sd_addr_t'(i_col);
                nxt_dqm = i_mask;
                nxt_oe_n = !i_we;
                nxt_cnt = dly(CAS_LAT + 1);
                nxt_st = i_we ? S_PRE : S_RDW;
            end
            S_RDW:
            begin
                // Deselect while data is in flight; the read must still land
                nxt_cmd = CMD_DESEL;
                if (cnt_done)
                    nxt_st = S_PRE;
            end
            S_PRE:
            begin
                // Close at once: bounds row time, frees the bank
                nxt_cmd = CMD_PRE;
                nxt_addr = '0;
                // Precharge plus wait covers row cycle and cross-bank spacing
                nxt_cnt = dly((TRC > TRP) ? TRC : TRP);
                nxt_ret = S_IDLE;
                nxt_st = S_WAIT;
            end
            S_WAIT:
                if (cnt_done)
                    nxt_st = ret_ff;
            default:
                nxt_st = S_PAUSE;
        endcase
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            st_ff <= S_PAUSE;
            ret_ff <= S_PAUSE;
            cnt_ff <= dly(PAUSE_CYC);
            ref_ff <= 4'h0;
            cmd_ff <= CMD_NOP;
            addr_ff <= '0;
            ba_ff <= 1'b0;
            dqm_ff <= 2'h3;
            oe_n_ff <= 1'b1;
        end
        else
        begin
            st_ff <= nxt_st;
            ret_ff <= nxt_ret;
            cnt_ff <= nxt_cnt;
            ref_ff <= nxt_ref;
            cmd_ff <= nxt_cmd;
            addr_ff <= nxt_addr;
            ba_ff <= nxt_ba;
            dqm_ff <= nxt_dqm;
            oe_n_ff <= nxt_oe_n;
        end
    end

    logic [3:0] pin_cmd;
    sd_data_t wd_ff;
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            ack_ff <= 1'b0;
            rdy_ff <= 1'b0;
            rdata_ff <= '0;
            wd_ff <= '0;
        end
        else
        begin
            // Reads acknowledge only once the data is captured
            ack_ff <= (st_ff == S_ACC && i_we) || cap_rd;
            rdy_ff <= nxt_st == S_IDLE;
            wd_ff <= i_wdata;
            if (cap_rd)
                rdata_ff <= link.dq;
        end
    end

    // Write data must coincide with the write command on the pins
    assign pin_cmd = cmd_ff[3:0];
    assign link.cs_n = pin_cmd[3];
    assign link.ras_n = pin_cmd[2];
    assign link.cas_n = pin_cmd[1];
    assign link.we_n = pin_cmd[0];
    assign link.cke = 1'b1;
    assign link.ba = ba_ff;
    assign link.addr = addr_ff;
    assign link.dqm = dqm_ff;
    assign link.dq_ctl_o = wd_ff;
    assign link.dq_ctl_oe_n = oe_n_ff;
    assign o_ack = ack_ff;
    assign o_ready = rdy_ff;
    assign o_rdata = rdata_ff;
endmodule

// [pkg/sdram_cmd_map.svh]
// Constants for the two-bank command link: pin widths, field positions, timing counts.
// Assumes a 100 MHz clock shared by both ends.
`ifndef SDRAM_CMD_MAP_SVH
`define SDRAM_CMD_MAP_SVH

// ----------------------------------------
// Pin widths and fields
// ----------------------------------------
`define SD_ADDR_W 11
`define SD_COL_W 8
`define SD_DATA_W 16
`define SD_ALLBANK_BIT 10
`define SD_RD_MASK_LAT 2
`define SD_MODE_RST 11'h000

// ----------------------------------------
// Timing
// ----------------------------------------
`define SD_CLK_MHZ 100
`define SD_PAUSE_US 200
`define SD_PAUSE_CYC (`SD_PAUSE_US * `SD_CLK_MHZ)
`define SD_INIT_REFRESH 8
`define SD_TRSC_CYC 2
`define SD_TRCD_CYC 2
`define SD_TRP_CYC 2
`define SD_TRC_CYC 7
`define SD_TRRD_CYC 2
`define SD_TRFC_CYC 7
`define SD_TRAS_MAX_CYC 10000
`define SD_CAS_LAT 2

`endif

// [pkg/sdram_cmd_pkg.sv]
// Types shared by both ends of the command link.
// Assumes the constants header is on the include path.
`include "sdram_cmd_map.svh"
package sdram_cmd_pkg;
    typedef enum logic [3:0] {
        CMD_MRS = 4'h0,
        CMD_REF = 4'h1,
        CMD_PRE = 4'h2,
        CMD_ACT = 4'h3,
        CMD_WR = 4'h4,
        CMD_RD = 4'h5,
        CMD_STOP = 4'h6,
        CMD_NOP = 4'h7,
        CMD_DESEL = 4'h8
    } sd_cmd_e;
    typedef logic [`SD_ADDR_W-1:0] sd_addr_t;
    typedef logic [`SD_DATA_W-1:0] sd_data_t;
endpackage

// [pkg/sdram_link_if.sv]
// Pin-level link between controller and memory end.
// Resolves the data bus itself from the two enables.
interface sdram_link_if;
    import sdram_cmd_pkg::*;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic cke;
    logic ba;
    sd_addr_t addr;
    logic [1:0] dqm;
    sd_data_t dq_ctl_o;
    logic dq_ctl_oe_n;
    sd_data_t dq_mem_o;
    logic [1:0] dq_mem_oe_n;
    // A released byte reads back inverted, so a floated byte cannot pass for data
    wire [7:0] dq_mem_lo = dq_mem_oe_n[0] ? ~dq_mem_o[7:0] : dq_mem_o[7:0];
    wire [7:0] dq_mem_hi = dq_mem_oe_n[1] ? ~dq_mem_o[15:8] : dq_mem_o[15:8];
    wire sd_data_t dq = !dq_ctl_oe_n ? dq_ctl_o : {dq_mem_hi, dq_mem_lo};
    modport ctl (output cs_n, ras_n, cas_n, we_n, cke, ba, addr, dqm, dq_ctl_o, dq_ctl_oe_n, input dq);
    modport mem (input cs_n, ras_n, cas_n, we_n, cke, ba, addr, dqm, dq, output dq_mem_o, dq_mem_oe_n);
endinterface

// [rtl/sdram_cmd_decode.sv]
// Command decoder of the memory end: strobes to command code.
// Assumes strobes are synchronous to the clock.
module sdram_cmd_decode
(
    input wire logic i_cs_n,
    input wire logic i_ras_n,
    input wire logic i_cas_n,
    input wire logic i_we_n,
    output sdram_cmd_pkg::sd_cmd_e o_cmd
);
    import sdram_cmd_pkg::*;
    wire [2:0] strobes = {i_ras_n, i_cas_n, i_we_n};
    // Deselect hides the strobes entirely
    assign o_cmd = i_cs_n ? CMD_DESEL : sd_cmd_e'({1'b0, strobes});
endmodule

// [rtl/sdram_mem_end.sv]
// Memory end of the link: two banks, row/column access, byte masks, clock enable.
// Assumes the controller keeps every timing interval; storage is a small parameterised array.
module sdram_mem_end
#(
    parameter int COL_W = `SD_COL_W,
    parameter int ROW_KEEP = 2
)
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    sdram_link_if.mem link,
    output logic [`SD_ADDR_W-1:0] o_mode,
    output logic o_mode_valid,
    output logic [1:0] o_bank_open,
    output logic o_low_power
);
    import sdram_cmd_pkg::*;
    localparam int DEPTH = 2 * (2 ** ROW_KEEP) * (2 ** COL_W);
    localparam int AW = 1 + ROW_KEEP + COL_W;
    sd_data_t mem [DEPTH];
    sd_cmd_e cmd;
    logic [ROW_KEEP-1:0] row_ff [2];
    logic [1:0] open_ff;
    logic [`SD_ADDR_W-1:0] mode_ff;
    logic mode_ok_ff;
    logic lp_ff;
    logic rd_ff [`SD_RD_MASK_LAT];
    logic [AW-1:0] rd_a_ff [`SD_RD_MASK_LAT];
    logic [1:0] dm_ff [`SD_RD_MASK_LAT];
    sd_data_t q_ff;
    logic [1:0] oe_n_ff;

    function automatic logic [AW-1:0] loc(input logic b, input logic [ROW_KEEP-1:0] r, input logic [COL_W-1:0] c);
        loc = {b, r, c};
    endfunction

    sdram_cmd_decode u_dec
    (
        .i_cs_n(link.cs_n),
        .i_ras_n(link.ras_n),
        .i_cas_n(link.cas_n),
        .i_we_n(link.we_n),
        .o_cmd(cmd)
    );

    wire live = link.cke;
    wire [COL_W-1:0] col = link.addr[COL_W-1:0];
    wire [AW-1:0] acc_a = loc(link.ba, row_ff[link.ba], col);
    wire is_wr = live && cmd == CMD_WR;
    wire is_rd = live && cmd == CMD_RD;
    wire pre_all = link.addr[`SD_ALLBANK_BIT];

    // ----------------------------------------
    // Bank state and mode
    // ----------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            open_ff <= 2'h0;
            mode_ff <= `SD_MODE_RST;
            mode_ok_ff <= 1'b0;
            lp_ff <= 1'b0;
            row_ff[0] <= '0;
            row_ff[1] <= '0;
        end
        else
        begin
            lp_ff <= !link.cke;
            if (live && cmd == CMD_ACT)
            begin
                open_ff[link.ba] <= 1'b1;
                row_ff[link.ba] <= link.addr[ROW_KEEP-1:0];
            end
            if (live && cmd == CMD_PRE)
            begin
                if (pre_all)
                    open_ff <= 2'h0;
                else
                    open_ff[link.ba] <= 1'b0;
            end
            if (live && cmd == CMD_MRS)
            begin
                mode_ff <= link.addr;
                mode_ok_ff <= 1'b1;
            end
        end
    end

    // Write mask acts the same cycle
    always_ff @(posedge i_clk)
    begin
        if (is_wr && !link.dqm[0])
            mem[acc_a][7:0] <= link.dq[7:0];
        if (is_wr && !link.dqm[1])
            mem[acc_a][15:8] <= link.dq[15:8];
    end

    // ----------------------------------------
    // Read pipe: mask sampled now drives Hi-Z two edges later
    // ----------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            for (int i = 0; i < `SD_RD_MASK_LAT; i++)
            begin
                rd_ff[i] <= 1'b0;
                rd_a_ff[i] <= '0;
                dm_ff[i] <= 2'h3;
            end
            q_ff <= '0;
            oe_n_ff <= 2'h3;
        end
        else if (live)
        begin
            // Deselect leaves the pipe running
            rd_ff[0] <= is_rd;
            rd_a_ff[0] <= acc_a;
            dm_ff[0] <= link.dqm;
            for (int i = 1; i < `SD_RD_MASK_LAT; i++)
            begin
                rd_ff[i] <= rd_ff[i-1];
                rd_a_ff[i] <= rd_a_ff[i-1];
                dm_ff[i] <= dm_ff[i-1];
            end
            q_ff <= mem[rd_a_ff[`SD_RD_MASK_LAT-2]];
            oe_n_ff <= rd_ff[`SD_RD_MASK_LAT-2] ? dm_ff[`SD_RD_MASK_LAT-2] : 2'h3;
        end
    end

    assign link.dq_mem_o = q_ff;
    assign link.dq_mem_oe_n = oe_n_ff;
    assign o_mode = mode_ff;
    assign o_mode_valid = mode_ok_ff;
    assign o_bank_open = open_ff;
    assign o_low_power = lp_ff;
endmodule

// [dv/sdram_link_assertions.sv]
// Checker for the pin-level command link between the two ends.
// Assumes it is instantiated in tb beside the link interface.
// ----------------------------------------
// Command timing and data bus ownership
// ----------------------------------------
module sdram_link_assertions
#(
    parameter int PAUSE_CYC = 20
)
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic cke,
    input wire logic ba,
    input wire sdram_cmd_pkg::sd_addr_t addr,
    input wire logic [1:0] dqm,
    input wire logic dq_ctl_oe_n,
    input wire logic [1:0] dq_mem_oe_n
);
    timeunit 1ns;
    timeprecision 1ns;
    wire cmd = !cs_n && !(ras_n && cas_n && we_n);
    wire act = !cs_n && !ras_n && cas_n && we_n;
    wire acc = !cs_n && ras_n && !cas_n;
    wire rd = acc && we_n;
    wire pre = !cs_n && !ras_n && cas_n && !we_n;
    wire refr = !cs_n && !ras_n && !cas_n && we_n;
    wire mrs = !cs_n && !ras_n && !cas_n && !we_n;
    int cyc_ff;
    logic prea_ff;
    logic [3:0] refs_ff;

    // Saturating, so long runs cannot wrap
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            cyc_ff <= 0;
            prea_ff <= 1'b0;
            refs_ff <= 4'h0;
        end
        else
        begin
            if (cyc_ff < PAUSE_CYC)
                cyc_ff <= cyc_ff + 1;
            if (pre && addr[10])
                prea_ff <= 1'b1;
            if (refr && refs_ff < 4'hF)
                refs_ff <= refs_ff + 4'h1;
        end
    end

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);

    pause_quiet_a: assert property (cmd |-> cyc_ff >= PAUSE_CYC - 1)
        else $error("command during power-up pause");
    pause_masks_a: assert property ((cyc_ff < PAUSE_CYC - 1) |-> (dqm == 2'h3 && cke))
        else $error("masks or clock enable low during pause");
    prea_first_a: assert property (refr |-> prea_ff)
        else $error("refresh before precharge of all banks");
    mrs_order_a: assert property (mrs |-> (refs_ff == 4'h8 && prea_ff))
        else $error("mode set out of order");
    mrs_gap_a: assert property (mrs |=> !cmd)
        else $error("command inside mode set cycle time");
    act_gap_a: assert property (act |=> (!act) [*6])
        else $error("activates too close");
    rcd_gap_a: assert property (acc |->
        ($past(act, 2) && $past(ba, 2) == ba) || ($past(act, 3) && $past(ba, 3) == ba))
        else $error("access without matching activate");
    row_close_a: assert property (acc |-> ##[1:4] pre)
        else $error("row left open after access");
    rd_float_a: assert property (rd |-> ##2 (dq_mem_oe_n == $past(dqm, 2)))
        else $error("read byte drive does not follow mask");
    mem_quiet_a: assert property ((dq_mem_oe_n != 2'h3) |-> $past(rd, 2))
        else $error("memory drives bus outside read slot");
    wr_drive_a: assert property ((acc && !we_n) |-> (!dq_ctl_oe_n && dq_mem_oe_n == 2'h3))
        else $error("write data not driven by controller");
endmodule

// [dv/tb.sv]
// Bench joining controller end and memory end over the link interface.
// Assumes a short power-up pause parameter for simulation.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import sdram_cmd_pkg::*;
    localparam int PAUSE = 20;
    localparam logic [10:0] MODE = 11'h155;
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_req = 1'b0;
    logic i_we = 1'b0;
    logic i_ba = 1'b0;
    sd_addr_t i_row = 11'h000;
    logic [7:0] i_col = 8'h00;
    sd_data_t i_wdata = 16'h0000;
    logic [1:0] i_mask = 2'h0;
    logic o_ready;
    logic o_ack;
    sd_data_t o_rdata;
    logic [10:0] o_mode;
    logic o_mode_valid;
    logic o_low_power;
    logic [1:0] o_bank_open;
    int miscompares = 0;
    int checked = 0;

    sdram_link_if link_if();
    sdram_ctl_end #(.PAUSE_CYC(PAUSE), .MODE_VAL(MODE)) sdram_ctl_end_inst (.i_clk(i_clk),
        .i_sys_rst(i_sys_rst), .link(link_if.ctl), .i_req(i_req), .i_we(i_we), .i_ba(i_ba),
        .i_row(i_row), .i_col(i_col), .i_wdata(i_wdata), .i_mask(i_mask), .o_ready(o_ready),
        .o_ack(o_ack), .o_rdata(o_rdata));
    sdram_mem_end sdram_mem_end_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .link(link_if.mem),
        .o_mode(o_mode), .o_mode_valid(o_mode_valid), .o_bank_open(o_bank_open), .o_low_power(o_low_power));
    sdram_link_assertions #(.PAUSE_CYC(PAUSE)) sdram_link_assertions_inst (.i_clk(i_clk),
        .i_sys_rst(i_sys_rst), .cs_n(link_if.cs_n), .ras_n(link_if.ras_n), .cas_n(link_if.cas_n),
        .we_n(link_if.we_n), .cke(link_if.cke), .ba(link_if.ba), .addr(link_if.addr),
        .dqm(link_if.dqm), .dq_ctl_oe_n(link_if.dq_ctl_oe_n), .dq_mem_oe_n(link_if.dq_mem_oe_n));

    initial
    begin
        forever #5 i_clk = ~i_clk;
    end

    task automatic test_done;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk_w(input string what, input logic [15:0] exp, input logic [15:0] seen);
        checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic chk_b(input string what, input logic exp, input logic seen);
        checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value %s expected %b seen %b", what, exp, seen);
        end
    endtask

    // Holds the request until acknowledged; bounded so a hang ends the run
    task automatic op(input logic we, input logic ba, input sd_addr_t row, input logic [7:0] col,
        input sd_data_t d, input logic [1:0] m, output sd_data_t q);
        int n;
        @(negedge i_clk);
        i_req = 1'b1;
        i_we = we;
        i_ba = ba;
        i_row = row;
        i_col = col;
        i_wdata = d;
        i_mask = m;
        n = 0;
        while (o_ack !== 1'b1 && n < 300)
        begin
            @(negedge i_clk);
            n++;
        end
        if (n == 300)
        begin
            miscompares++;
            test_done();
        end
        q = o_rdata;
        chk_b("bank open", 1'b1, o_bank_open[ba]);
        chk_b("other bank closed", 1'b0, o_bank_open[!ba]);
        i_req = 1'b0;
    endtask

    task automatic t_init;
        int n;
        n = 0;
        chk_b("mode valid at reset", 1'b0, o_mode_valid);
        while (o_ready !== 1'b1 && n < 300)
        begin
            @(negedge i_clk);
            n++;
        end
        chk_b("ready after init", 1'b1, o_ready);
        if (o_ready !== 1'b1)
            test_done();
        chk_w("mode", {5'h00, MODE}, {5'h00, o_mode});
        chk_b("mode valid", 1'b1, o_mode_valid);
        chk_b("low power", 1'b0, o_low_power);
    endtask

    task automatic t_rows_banks;
        sd_data_t q;
        op(1'b1, 1'b0, 11'h001, 8'hFF, 16'hA5C3, 2'h0, q);
        op(1'b1, 1'b1, 11'h001, 8'hFF, 16'h1234, 2'h0, q);
        op(1'b1, 1'b0, 11'h002, 8'hFF, 16'h0F0F, 2'h0, q);
        op(1'b0, 1'b0, 11'h001, 8'hFF, 16'h0000, 2'h0, q);
        chk_w("bank0 row1", 16'hA5C3, q);
        op(1'b0, 1'b1, 11'h001, 8'hFF, 16'h0000, 2'h0, q);
        chk_w("bank1 row1", 16'h1234, q);
        op(1'b0, 1'b0, 11'h002, 8'hFF, 16'h0000, 2'h0, q);
        chk_w("bank0 row2", 16'h0F0F, q);
    endtask

    // Every mask code on writes, then each single-byte mask on reads
    task automatic t_masks;
        sd_data_t q;
        sd_data_t cur;
        sd_data_t d;
        cur = 16'hA5C3;
        for (int m = 0; m < 4; m++)
        begin
            d = 16'(16'h1111 * (m + 5));
            op(1'b1, 1'b0, 11'h001, 8'hFF, d, m[1:0], q);
            cur = {m[1] ? cur[15:8] : d[15:8], m[0] ? cur[7:0] : d[7:0]};
            op(1'b0, 1'b0, 11'h001, 8'hFF, 16'h0000, 2'h0, q);
            chk_w("write mask merge", cur, q);
        end
        op(1'b0, 1'b0, 11'h001, 8'hFF, 16'h0000, 2'h2, q);
        chk_w("read low byte", {~cur[15:8], cur[7:0]}, q);
        op(1'b0, 1'b0, 11'h001, 8'hFF, 16'h0000, 2'h1, q);
        chk_w("read high byte", {cur[15:8], ~cur[7:0]}, q);
        chk_w("mode kept", {5'h00, MODE}, {5'h00, o_mode});
    endtask

    initial
    begin
        repeat (4) @(negedge i_clk);
        i_sys_rst = 1'b0;
        t_init();
        t_rows_banks();
        t_masks();
        test_done();
    end
endmodule
